/* rtl/bsdp_pkg.sv */
// bsdp_pkg: constants, types and encodings for the bank switched dual port ram.
// assumes both ports and their hosts run on the single 50 MHz system clock.
package bsdp_pkg;

   // ==========================================================
   // geometry
   localparam int BSDP_PORTS = 2;
   localparam int BSDP_DATA_W = 36;
   localparam int BSDP_LANE_W = 9;
   localparam int BSDP_LANES = 4;
   localparam int BSDP_BANK_W = 6;
   localparam int BSDP_WORD_W = 10;
   localparam int BSDP_ADDR_W = BSDP_BANK_W + BSDP_WORD_W;
   localparam int BSDP_DEPTH = 1 << BSDP_ADDR_W;

   // ==========================================================
   // reset values and timing
   localparam logic [BSDP_ADDR_W-1:0] BSDP_ADDR_RST = 16'h0000;
   localparam logic [BSDP_DATA_W-1:0] BSDP_DATA_RST = 36'h0_0000_0000;
   localparam logic [BSDP_LANES-1:0] BSDP_LANES_OFF = 4'h0;
   localparam logic [BSDP_ADDR_W-1:0] BSDP_ADDR_STEP = 16'h0001;
   localparam logic [BSDP_ADDR_W-1:0] BSDP_ADDR_TOP = 16'hFFFF;
   localparam int BSDP_CLK_PERIOD_NS = 20;
   localparam int BSDP_SELECT_CYC = 2;
   localparam int BSDP_PIPE_EXTRA_CYC = 1;

   // ==========================================================
   // port power state, one-hot
   typedef enum logic [2:0] {
      BSDP_PWR_DOWN = 3'h1,
      BSDP_PWR_WAKE = 3'h2,
      BSDP_PWR_ACTIVE = 3'h4
   } bsdp_pwr_t;

   // ==========================================================
   // one port's request pins
   typedef struct packed {
      logic chip_select_low_active;
      logic chip_select_high_active;
      logic rd_wr_n;
      logic address_load_strobe_n;
      logic counter_advance_n;
      logic counter_reload_n;
      logic [BSDP_LANES-1:0] byte_lane_enable_n;
      logic [BSDP_BANK_W-1:0] bank_select;
      logic [BSDP_WORD_W-1:0] word_addr;
      logic [BSDP_DATA_W-1:0] wdata;
   } bsdp_req_t;

   // one port's data pins
   typedef struct packed {
      logic [BSDP_DATA_W-1:0] data;
      logic [BSDP_LANES-1:0] drive_n;
   } bsdp_rsp_t;

endpackage : bsdp_pkg

/* rtl/bsdp_ram_port.sv */
// bsdp_ram_port: shared array with two synchronous access ports, burst counters,
// flow-through or pipelined output and per-lane output enables.
// assumes both hosts drive requests from logic on CLK_IN and keep the mode pins static.
`timescale 1ns/1ps
module bsdp_ram_port
   import bsdp_pkg::*;
(
   input wire logic CLK_IN, // system clock, 50 MHz
   input wire logic RST_N_IN, // synchronous reset, active low
   input wire bsdp_req_t REQ_A_IN, // port a request pins
   input wire bsdp_req_t REQ_B_IN, // port b request pins
   input wire logic OE_N_A_IN, // port a output drive enable, async
   input wire logic OE_N_B_IN, // port b output drive enable, async
   input wire logic LATENCY_MODE_SELECT_A_IN, // port a: 1 pipelined, 0 flow-through
   input wire logic LATENCY_MODE_SELECT_B_IN, // port b: 1 pipelined, 0 flow-through
   output bsdp_rsp_t RSP_A_OUT, // port a data and lane enables
   output bsdp_rsp_t RSP_B_OUT, // port b data and lane enables
   output logic [BSDP_PORTS-1:0] BANK_CLASH_OUT // read data hit a same-bank clash
);

   // ==========================================================
   // helpers
   function automatic logic port_sel(input bsdp_req_t r);
      return !r.chip_select_low_active && r.chip_select_high_active;
   endfunction : port_sel

   function automatic logic [BSDP_ADDR_W-1:0] ext_addr(input bsdp_req_t r);
      return {r.bank_select, r.word_addr};
   endfunction : ext_addr

   function automatic logic [BSDP_ADDR_W-1:0] bank_of(input logic [BSDP_ADDR_W-1:0] a);
      return {a[BSDP_ADDR_W-1 -: BSDP_BANK_W], {BSDP_WORD_W{1'b0}}};
   endfunction : bank_of

   function automatic logic [BSDP_DATA_W-1:0] lane_mask(input logic [BSDP_LANES-1:0] l);
      logic [BSDP_DATA_W-1:0] m;
      for (int i = 0; i < BSDP_LANES; i++) begin
         m[i*BSDP_LANE_W +: BSDP_LANE_W] = {BSDP_LANE_W{l[i]}};
      end
      return m;
   endfunction : lane_mask

   // ==========================================================
   // declarations
   bsdp_req_t req_in [BSDP_PORTS];
   bsdp_req_t req_ff [BSDP_PORTS];
   bsdp_req_t nxt_req [BSDP_PORTS];
   logic [BSDP_ADDR_W-1:0] cnt_ff [BSDP_PORTS];
   logic [BSDP_ADDR_W-1:0] nxt_cnt [BSDP_PORTS];
   logic [BSDP_ADDR_W-1:0] load_ff [BSDP_PORTS];
   logic [BSDP_ADDR_W-1:0] nxt_load [BSDP_PORTS];
   logic [BSDP_ADDR_W-1:0] int_addr [BSDP_PORTS];
   bsdp_pwr_t pwr_ff [BSDP_PORTS];
   bsdp_pwr_t nxt_pwr [BSDP_PORTS];
   logic [BSDP_PORTS-1:0] sel;
   logic [BSDP_PORTS-1:0] awake;
   logic clash;
   logic [BSDP_LANES-1:0] lane_we [BSDP_PORTS];
   logic [BSDP_DATA_W-1:0] rd_word [BSDP_PORTS];
   logic [BSDP_DATA_W-1:0] ft_data_ff [BSDP_PORTS];
   logic [BSDP_DATA_W-1:0] nxt_ft_data [BSDP_PORTS];
   logic [BSDP_DATA_W-1:0] pl_data_ff [BSDP_PORTS];
   logic [BSDP_DATA_W-1:0] nxt_pl_data [BSDP_PORTS];
   logic [BSDP_LANES-1:0] ft_drv_ff [BSDP_PORTS];
   logic [BSDP_LANES-1:0] nxt_ft_drv [BSDP_PORTS];
   logic [BSDP_LANES-1:0] pl_drv_ff [BSDP_PORTS];
   logic [BSDP_LANES-1:0] nxt_pl_drv [BSDP_PORTS];
   logic [BSDP_PORTS-1:0] ft_clash_ff;
   logic [BSDP_PORTS-1:0] nxt_ft_clash;
   logic [BSDP_PORTS-1:0] pl_clash_ff;
   logic [BSDP_PORTS-1:0] nxt_pl_clash;
   logic [BSDP_PORTS-1:0] mode;
   logic [BSDP_PORTS-1:0] oe_n;
   logic [BSDP_LANES-1:0] drv_int [BSDP_PORTS];
   logic [BSDP_DATA_W-1:0] mem [BSDP_DEPTH];

   assign req_in[0] = REQ_A_IN;
   assign req_in[1] = REQ_B_IN;
   assign mode[0] = LATENCY_MODE_SELECT_A_IN;
   assign mode[1] = LATENCY_MODE_SELECT_B_IN;
   assign oe_n[0] = OE_N_A_IN;
   assign oe_n[1] = OE_N_B_IN;

   // ==========================================================
   // input registers
   always_comb begin
      for (int p = 0; p < BSDP_PORTS; p++) begin
         nxt_req[p] = req_in[p];
      end
   end

   always_ff @(posedge CLK_IN) begin
      for (int p = 0; p < BSDP_PORTS; p++) begin
         if (!RST_N_IN) begin
            req_ff[p] <= '{chip_select_low_active: 1'b1, rd_wr_n: 1'b1,
                           address_load_strobe_n: 1'b1, counter_advance_n: 1'b1,
                           counter_reload_n: 1'b1, byte_lane_enable_n: 4'hF,
                           default: '0};
         end else begin
            req_ff[p] <= nxt_req[p];
         end
      end
   end

   // ==========================================================
   // address counter and load register
   always_comb begin
      for (int p = 0; p < BSDP_PORTS; p++) begin
         sel[p] = port_sel(req_ff[p]);
         nxt_load[p] = load_ff[p];
         if (!req_ff[p].address_load_strobe_n) begin
            int_addr[p] = ext_addr(req_ff[p]);
            nxt_load[p] = ext_addr(req_ff[p]);
         end else if (!req_ff[p].counter_reload_n) begin
            int_addr[p] = load_ff[p];
         end else if (!req_ff[p].counter_advance_n) begin
            int_addr[p] = cnt_ff[p] + BSDP_ADDR_STEP;
         end else begin
            int_addr[p] = cnt_ff[p];
         end
         nxt_cnt[p] = int_addr[p];
      end
   end

   always_ff @(posedge CLK_IN) begin
      for (int p = 0; p < BSDP_PORTS; p++) begin
         if (!RST_N_IN) begin
            cnt_ff[p] <= BSDP_ADDR_RST;
            load_ff[p] <= BSDP_ADDR_RST;
         end else begin
            cnt_ff[p] <= nxt_cnt[p];
            load_ff[p] <= nxt_load[p];
         end
      end
   end

   // ==========================================================
   // power state: deselect drops a port to standby at once
   always_comb begin
      for (int p = 0; p < BSDP_PORTS; p++) begin
         case (pwr_ff[p])
            BSDP_PWR_DOWN: nxt_pwr[p] = sel[p] ? BSDP_PWR_WAKE : BSDP_PWR_DOWN;
            BSDP_PWR_WAKE: nxt_pwr[p] = sel[p] ? BSDP_PWR_ACTIVE : BSDP_PWR_DOWN;
            BSDP_PWR_ACTIVE: nxt_pwr[p] = sel[p] ? BSDP_PWR_ACTIVE : BSDP_PWR_DOWN;
            default: nxt_pwr[p] = BSDP_PWR_DOWN;
         endcase
         awake[p] = sel[p] && (pwr_ff[p] != BSDP_PWR_DOWN);
      end
   end

   always_ff @(posedge CLK_IN) begin
      for (int p = 0; p < BSDP_PORTS; p++) begin
         if (!RST_N_IN) begin
            pwr_ff[p] <= BSDP_PWR_DOWN;
         end else begin
            pwr_ff[p] <= nxt_pwr[p];
         end
      end
   end

   // ==========================================================
   // shared array: writes blocked while both ports sit in one bank
   assign clash = sel[0] && sel[1]
      && (bank_of(int_addr[0]) == bank_of(int_addr[1]));

   always_comb begin
      for (int p = 0; p < BSDP_PORTS; p++) begin
         for (int l = 0; l < BSDP_LANES; l++) begin
            lane_we[p][l] = sel[p] && !req_ff[p].rd_wr_n && !clash
               && !req_ff[p].byte_lane_enable_n[l];
         end
         rd_word[p] = mem[int_addr[p]];
      end
   end

   always_ff @(posedge CLK_IN) begin
      for (int p = 0; p < BSDP_PORTS; p++) begin
         for (int l = 0; l < BSDP_LANES; l++) begin
            if (lane_we[p][l]) begin
               mem[int_addr[p]][l*BSDP_LANE_W +: BSDP_LANE_W] <=
                  req_ff[p].wdata[l*BSDP_LANE_W +: BSDP_LANE_W];
            end
         end
      end
   end

   // ==========================================================
   // output stages: flow-through register and one extra pipelined register
   always_comb begin
      for (int p = 0; p < BSDP_PORTS; p++) begin
         nxt_ft_data[p] = sel[p] ? rd_word[p] : ft_data_ff[p];
         for (int l = 0; l < BSDP_LANES; l++) begin
            nxt_ft_drv[p][l] = awake[p] && req_ff[p].rd_wr_n
               && !req_ff[p].byte_lane_enable_n[l];
         end
         nxt_ft_clash[p] = clash && req_ff[p].rd_wr_n;
         nxt_pl_data[p] = ft_data_ff[p];
         nxt_pl_drv[p] = sel[p] ? ft_drv_ff[p] : BSDP_LANES_OFF;
         nxt_pl_clash[p] = ft_clash_ff[p];
      end
   end

   always_ff @(posedge CLK_IN) begin
      for (int p = 0; p < BSDP_PORTS; p++) begin
         if (!RST_N_IN) begin
            ft_data_ff[p] <= BSDP_DATA_RST;
            pl_data_ff[p] <= BSDP_DATA_RST;
            ft_drv_ff[p] <= BSDP_LANES_OFF;
            pl_drv_ff[p] <= BSDP_LANES_OFF;
            ft_clash_ff[p] <= 1'b0;
            pl_clash_ff[p] <= 1'b0;
         end else begin
            ft_data_ff[p] <= nxt_ft_data[p];
            pl_data_ff[p] <= nxt_pl_data[p];
            ft_drv_ff[p] <= nxt_ft_drv[p];
            pl_drv_ff[p] <= nxt_pl_drv[p];
            ft_clash_ff[p] <= nxt_ft_clash[p];
            pl_clash_ff[p] <= nxt_pl_clash[p];
         end
      end
   end

   // ==========================================================
   // pins: mode picks the stage, output enable gates lanes without a clock
   always_comb begin
      for (int p = 0; p < BSDP_PORTS; p++) begin
         drv_int[p] = mode[p] ? pl_drv_ff[p] : ft_drv_ff[p];
         BANK_CLASH_OUT[p] = mode[p] ? pl_clash_ff[p] : ft_clash_ff[p];
      end
   end

   assign RSP_A_OUT.data = mode[0] ? pl_data_ff[0] : ft_data_ff[0];
   assign RSP_B_OUT.data = mode[1] ? pl_data_ff[1] : ft_data_ff[1];
   assign RSP_A_OUT.drive_n = ~drv_int[0] | {BSDP_LANES{oe_n[0]}};
   assign RSP_B_OUT.drive_n = ~drv_int[1] | {BSDP_LANES{oe_n[1]}};

   // ==========================================================
   // checks
   default clocking chk_cb @(posedge CLK_IN);
   endclocking
   default disable iff (!RST_N_IN);

   for (genvar g = 0; g < BSDP_PORTS; g++) begin : g_chk
      chk_load_ext: assert property (
         !req_ff[g].address_load_strobe_n |-> int_addr[g] == ext_addr(req_ff[g])
      ) else $error("loaded address differs from external address");

      chk_load_each_edge: assert property (
         !req_ff[g].address_load_strobe_n ##1 !req_ff[g].address_load_strobe_n
         |-> load_ff[g] == $past(ext_addr(req_ff[g]))
      ) else $error("held load strobe missed an address");

      chk_hold_addr: assert property (
         req_ff[g].address_load_strobe_n && req_ff[g].counter_advance_n
         && req_ff[g].counter_reload_n |-> int_addr[g] == $past(int_addr[g])
      ) else $error("address moved without load or advance");

      chk_advance_step: assert property (
         req_ff[g].address_load_strobe_n && req_ff[g].counter_reload_n
         && !req_ff[g].counter_advance_n
         |-> int_addr[g] == $past(int_addr[g]) + BSDP_ADDR_STEP
      ) else $error("advance did not step by one");

      chk_counter_wrap: assert property (
         req_ff[g].address_load_strobe_n && req_ff[g].counter_reload_n
         && !req_ff[g].counter_advance_n && $past(int_addr[g]) == BSDP_ADDR_TOP
         |-> int_addr[g] == BSDP_ADDR_RST
      ) else $error("counter did not wrap to bank zero");

      chk_reload_addr: assert property (
         !req_ff[g].address_load_strobe_n ##1
         (req_ff[g].address_load_strobe_n && !req_ff[g].counter_reload_n)
         |-> int_addr[g] == $past(ext_addr(req_ff[g]))
      ) else $error("reload did not access the last loaded address");

      chk_reload_first: assert property (
         req_ff[g].address_load_strobe_n && !req_ff[g].counter_reload_n
         && !req_ff[g].counter_advance_n |=> cnt_ff[g] == load_ff[g]
      ) else $error("advance overrode reload");

      chk_ft_latency: assert property (
         !mode[g] && $past(sel[g]) |-> ft_data_ff[g] === $past(rd_word[g])
      ) else $error("flow-through data not one cycle after access");

      chk_pipe_latency: assert property (
         mode[g] && $past(sel[g], 2) |-> pl_data_ff[g] === $past(rd_word[g], 2)
      ) else $error("pipelined data not two cycles after access");

      chk_desel_float: assert property (
         !sel[g] |=> drv_int[g] == BSDP_LANES_OFF
      ) else $error("deselected port still drives after next edge");

      chk_lane_float: assert property (
         !mode[g] && req_ff[g].byte_lane_enable_n[0] |=> !drv_int[g][0]
      ) else $error("disabled lane still drives");

      chk_two_selected: assert property (
         ft_drv_ff[g] != BSDP_LANES_OFF |-> $past(sel[g]) && $past(sel[g], 2)
      ) else $error("data driven before two selected cycles");

      chk_power_down: assert property (
         !sel[g] |=> pwr_ff[g] == BSDP_PWR_DOWN
      ) else $error("deselected port not in standby");

      chk_lane_write: assert property (
         lane_we[g] != BSDP_LANES_OFF |-> !req_ff[g].rd_wr_n
         && (lane_we[g] & req_ff[g].byte_lane_enable_n) == BSDP_LANES_OFF
      ) else $error("write on a disabled lane or read cycle");

      chk_clash_blocks: assert property (
         clash |-> lane_we[g] == BSDP_LANES_OFF ##1 ft_clash_ff[g] == $past(req_ff[g].rd_wr_n)
      ) else $error("same-bank access not blocked and flagged");

      chk_pipe_lane_float: assert property (
         mode[g] && $past(req_ff[g].byte_lane_enable_n[0], 2) |-> !drv_int[g][0]
      ) else $error("disabled lane drives the delayed output");

      chk_select_wake: assert property (
         sel[g] && $past(sel[g]) |-> awake[g]
      ) else $error("port not awake after two selected cycles");

      chk_clash_ft_out: assert property (
         !mode[g] |-> BANK_CLASH_OUT[g] == $past(clash && req_ff[g].rd_wr_n)
      ) else $error("clash flag not aligned with flow-through data");

      chk_clash_pl_out: assert property (
         mode[g] |-> BANK_CLASH_OUT[g] == $past(clash && req_ff[g].rd_wr_n, 2)
      ) else $error("clash flag not aligned with pipelined data");

      chk_hold_data: assert property (
         sel[g] && $past(sel[g]) && int_addr[g] == $past(int_addr[g])
         && $past(lane_we[0]) == BSDP_LANES_OFF && $past(lane_we[1]) == BSDP_LANES_OFF
         |=> ft_data_ff[g] === $past(ft_data_ff[g])
      ) else $error("held address did not repeat its data");
   end

   chk_cross_write: assert property (
      lane_we[0] != BSDP_LANES_OFF && sel[1] && req_ff[1].rd_wr_n
      ##1 (sel[1] && int_addr[1] == $past(int_addr[0]) && !clash)
      |-> ((rd_word[1] ^ $past(req_ff[0].wdata)) & lane_mask($past(lane_we[0])))
         == '0
   ) else $error("opposite port did not see the write one cycle later");

endmodule : bsdp_ram_port

/* sim/bsdp_host_model.sv */
// bsdp_host_model: host controller on one ram port; drives requests, notes expected reads
// and checks them. assumes tb holds ref_mem and check(); each op call is one capture.
`timescale 1ns/1ps
module bsdp_host_model
   import bsdp_pkg::*;
#(
   parameter logic [BSDP_ADDR_W-1:0] IDLE_ADDR = 16'h8000
)
(
   input wire logic clk_in, // port clock
   input wire logic mode_in, // 1 pipelined, 0 flow-through
   input wire bsdp_rsp_t rsp_in, // data pins
   input wire logic clash_in, // clash flag of this port
   output bsdp_req_t req_out, // request pins
   output logic oe_n_out // output drive enable
);
   typedef struct packed {
      logic [BSDP_DATA_W-1:0] data;
      logic [BSDP_LANES-1:0] lanes_n;
      logic clash;
      int due;
   } bsdp_note_t;

   bsdp_note_t note_q[$];
   logic [BSDP_ADDR_W-1:0] cnt = 16'h0000;
   logic [BSDP_ADDR_W-1:0] last_ld = 16'h0000;
   logic prev_sel = 1'b0;
   int cyc = 0;

   initial begin
      req_out = '0;
      req_out.chip_select_low_active = 1'b1;
      req_out.rd_wr_n = 1'b1;
      req_out.address_load_strobe_n = 1'b1;
      req_out.counter_advance_n = 1'b1;
      req_out.counter_reload_n = 1'b1;
      req_out.byte_lane_enable_n = 4'hF;
      oe_n_out = 1'b0;
   end

   // ==========================================================
   // request driver
   task automatic op(input logic sel, wr, ld, adv, rl, input logic [3:0] ln,
      input logic [15:0] a, input logic [35:0] wd, input logic clash);
      bsdp_req_t r;
      logic [15:0] acc;
      @(posedge clk_in);
      r.chip_select_low_active = !sel;
      r.chip_select_high_active = sel;
      r.rd_wr_n = !wr;
      r.address_load_strobe_n = !ld;
      r.counter_advance_n = !adv;
      r.counter_reload_n = !rl;
      r.byte_lane_enable_n = ln;
      r.bank_select = a[15:10];
      r.word_addr = a[9:0];
      r.wdata = wd;
      req_out <= r;
      acc = ld ? a : rl ? last_ld : adv ? cnt + 16'h0001 : cnt;
      cnt = acc;
      last_ld = ld ? a : last_ld;
      if (sel && wr && !clash) begin
         for (int l = 0; l < 4; l++) begin
            if (!ln[l]) tb.ref_mem[acc][9*l +: 9] = wd[9*l +: 9];
         end
      end
      if (sel && !wr && prev_sel && !oe_n_out && ln != 4'hF) begin
         note_q.push_back('{tb.ref_mem[acc], ln, clash, cyc + 3 + int'(mode_in)});
      end
      prev_sel = sel;
   endtask : op

   // idle cycle parks on a private bank so the ports never meet by accident
   task automatic idle_cycle();
      op(1'b1, 1'b0, 1'b1, 1'b0, 1'b0, 4'hF, IDLE_ADDR, 36'h0_0000_0000, 1'b0);
   endtask : idle_cycle

   task automatic set_oe(input logic v);
      @(posedge clk_in);
      oe_n_out <= v;
   endtask : set_oe

   // ==========================================================
   // result watcher
   always @(negedge clk_in) begin
      bsdp_note_t n;
      logic [35:0] m;
      cyc = cyc + 1;
      if (rsp_in.drive_n !== 4'hF) begin
         if (note_q.size() == 0) begin
            tb.check("unexpected drive", rsp_in.drive_n, 4'hF);
         end else begin
            n = note_q.pop_front();
            for (int l = 0; l < 4; l++) m[9*l +: 9] = {9{!n.lanes_n[l]}};
            tb.check("drive lanes", rsp_in.drive_n, n.lanes_n);
            tb.check("latency", cyc, n.due);
            tb.check("clash flag", clash_in, n.clash);
            if (!n.clash) tb.check("read data", rsp_in.data & m, n.data & m);
         end
      end
   end
endmodule : bsdp_host_model

/* sim/tb.sv */
// tb: two host models drive the dual port ram, one pipelined and one flow-through.
// assumes a single 50 MHz clock for both ports.
`timescale 1ns/1ps
module tb
   import bsdp_pkg::*;
();
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic mode_a = 1'b1;
   logic mode_b = 1'b0;
   bsdp_req_t req_a;
   bsdp_req_t req_b;
   logic oe_n_a;
   logic oe_n_b;
   bsdp_rsp_t rsp_a;
   bsdp_rsp_t rsp_b;
   logic [1:0] clash;
   logic [35:0] ref_mem [logic [15:0]];
   logic [15:0] seam [6] = '{16'h03FE, 16'h03FF, 16'h0400, 16'h0401, 16'hFFFF, 16'h0000};
   logic [15:0] addr_q[$];
   int err_count = 0;
   int tests_run = 0;
   int cycles = 0;
   int seed = 32'h96d1;

   bsdp_ram_port u_dut (.CLK_IN(clk), .RST_N_IN(rst_n), .REQ_A_IN(req_a), .REQ_B_IN(req_b),
      .OE_N_A_IN(oe_n_a), .OE_N_B_IN(oe_n_b), .LATENCY_MODE_SELECT_A_IN(mode_a),
      .LATENCY_MODE_SELECT_B_IN(mode_b), .RSP_A_OUT(rsp_a), .RSP_B_OUT(rsp_b),
      .BANK_CLASH_OUT(clash));
   bsdp_host_model #(.IDLE_ADDR(16'h8000)) u_a (.clk_in(clk), .mode_in(mode_a),
      .rsp_in(rsp_a), .clash_in(clash[0]), .req_out(req_a), .oe_n_out(oe_n_a));
   bsdp_host_model #(.IDLE_ADDR(16'hC000)) u_b (.clk_in(clk), .mode_in(mode_b),
      .rsp_in(rsp_b), .clash_in(clash[1]), .req_out(req_b), .oe_n_out(oe_n_b));

   // ==========================================================
   // helpers
   task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
      tests_run++;
      if (seen !== exp) begin
         err_count++;
         $display("CHECK FAILED %s expected %0h seen %0h", what, exp, seen);
      end
   endtask : check

   task automatic conclude();
      $display("checks %0d mismatches %0d", tests_run, err_count);
      if (err_count == 0 && tests_run > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask : conclude

   task automatic done(input string name);
      repeat (5) @(posedge clk);
      $display("test %s done", name);
   endtask : done

   function automatic logic [35:0] rnd();
      logic [63:0] v;
      v = {$random(seed), $random(seed)};
      return v[35:0];
   endfunction : rnd

   initial begin
      forever #10 clk = ~clk;
   end

   always @(posedge clk) begin
      cycles++;
      if (cycles == 3000) begin
         err_count++;
         conclude();
      end
   end

   // ==========================================================
   // main sequence
   initial begin
      logic [15:0] a;
      repeat (6) @(posedge clk);
      rst_n <= 1'b1;
      u_a.idle_cycle();
      u_a.op(1, 1, 1, 0, 0, 4'h0, 16'h03FE, rnd(), 0);
      repeat (3) u_a.op(1, 1, 0, 1, 0, 4'h0, 16'h0000, rnd(), 0);
      u_a.op(1, 1, 1, 0, 0, 4'h0, 16'hFFFF, rnd(), 0);
      u_a.op(1, 1, 0, 1, 0, 4'h0, 16'h0000, rnd(), 0);
      u_a.idle_cycle();
      u_b.idle_cycle();
      foreach (seam[i]) u_b.op(1, 0, 1, 0, 0, 4'h0, seam[i], 0, 0);
      u_b.idle_cycle();
      done("burst write");
      u_a.op(1, 0, 1, 0, 0, 4'h0, 16'h03FE, 0, 0);
      repeat (2) u_a.op(1, 0, 0, 1, 0, 4'h0, 16'h0000, 0, 0);
      u_a.op(1, 0, 0, 0, 0, 4'h0, 16'h0000, 0, 0);
      u_a.op(1, 0, 0, 1, 1, 4'h0, 16'h0000, 0, 0);
      u_a.op(1, 0, 1, 0, 1, 4'h0, 16'hFFFF, 0, 0);
      u_a.op(1, 0, 0, 0, 1, 4'h0, 16'h0000, 0, 0);
      u_a.op(1, 0, 0, 1, 0, 4'h0, 16'h0000, 0, 0);
      u_a.idle_cycle();
      done("counter read");
      fork
         begin
            u_a.op(1, 1, 1, 0, 0, 4'h5, 16'h0400, rnd(), 0);
            u_a.idle_cycle();
         end
         begin
            @(posedge clk);
            u_b.op(1, 0, 1, 0, 0, 4'h3, 16'h0400, 0, 0);
            u_b.idle_cycle();
         end
      join
      u_b.op(0, 0, 0, 0, 0, 4'hF, 16'hC000, 0, 0);
      u_b.op(1, 0, 1, 0, 0, 4'h0, 16'h0400, 0, 0);
      u_b.op(1, 0, 1, 0, 0, 4'h0, 16'h03FF, 0, 0);
      u_b.idle_cycle();
      done("lanes and select");
      fork
         begin
            u_a.op(1, 1, 1, 0, 0, 4'h0, 16'h0000, rnd(), 1);
            u_a.op(1, 0, 1, 0, 0, 4'h0, 16'h0401, 0, 1);
            u_a.idle_cycle();
         end
         begin
            u_b.op(1, 1, 1, 0, 0, 4'h0, 16'h0010, rnd(), 1);
            u_b.op(1, 0, 1, 0, 0, 4'h0, 16'h0401, 0, 1);
            u_b.idle_cycle();
         end
      join
      u_a.op(1, 0, 1, 0, 0, 4'h0, 16'h0000, 0, 0);
      u_a.idle_cycle();
      done("bank clash");
      u_a.set_oe(1'b1);
      u_a.op(1, 0, 1, 0, 0, 4'h0, 16'h0401, 0, 0);
      u_a.idle_cycle();
      repeat (4) @(posedge clk);
      u_a.set_oe(1'b0);
      done("output enable");
      repeat (12) begin
         a = 16'($random(seed)) & 16'h1FFF;
         addr_q.push_back(a);
         u_a.op(1, 1, 1, 0, 0, 4'h0, a, rnd(), 0);
      end
      u_a.idle_cycle();
      addr_q.shuffle();
      foreach (addr_q[i]) u_b.op(1, 0, 1, 0, 0, 4'($random(seed)), addr_q[i], 0, 0);
      u_b.idle_cycle();
      done("random");
      check("queue a", u_a.note_q.size(), 0);
      check("queue b", u_b.note_q.size(), 0);
      conclude();
   end
endmodule : tb
